// File: hw/lcd_segment_common_driver.v
`timescale 1ns/1ns
`include "lcd_drv_regs.vh"
// Behaviour
// - pixel bit one drives dark, zero drives clear.
// - one bit per segment and common; row index com*8+seg/8, bit seg%8.
// - bias reference bit 7 selects internal ladder, clear means external.
// - with ladder on, contrast follows three-bit contrast level.
// - bias reference bit 6 selects contrast circuit supply.
// - bias reference bits choose internal or external per bias level.
// - ladder power register picks power modes and interval in each.
// - with ladder off, pump enabled takes contrast from pump bits 5:3.
// - pump third-bias bit set gives one-third, clear gives static.
// - pump clock from its own two-bit select field.
// - static and two commons divide clock by 4*(prescaler+1).
// - three to eight commons divide by commons*(prescaler+1).
// - frame clock from three sources by two-bit select.
// - fixed divider to about 1 kHz; prescaler is the only knob.
// - Type-A inverts inside each common slot; Type-B per frame.
// - every pixel averages zero DC over the balancing period.
// - dark pixels see full drive, clear pixels at most one third.
// - static drive is the same for both types, two levels.
// - Type-A has twice as many slices as commons, four levels.
// - Type-B has as many slices as commons.
// - sleep-capable sources keep the display running in sleep.
// - waveform type bit zero gives Type-A, one gives Type-B.
// - control bit 7 starts or stops all display driving.
module lcd_segment_common_driver #(
  parameter [15:0] HALF_DIV_FAST = `DIV_FAST_HALF,
  parameter [15:0] HALF_DIV_SEC  = `DIV_SEC_HALF,
  parameter [15:0] HALF_DIV_SLOW = `DIV_SLOW_HALF,
  parameter        NSEG          = 64
) (
  // system
  input  wire              CLK,
  input  wire              RST,
  // axi4-lite write
  input  wire              AWVALID,
  output wire              AWREADY,
  input  wire [11:0]       AWADDR,
  input  wire [2:0]        AWPROT,
  input  wire              WVALID,
  output wire              WREADY,
  input  wire [31:0]       WDATA,
  input  wire [3:0]        WSTRB,
  output reg               BVALID,
  input  wire              BREADY,
  output reg  [1:0]        BRESP,
  // axi4-lite read
  input  wire              ARVALID,
  output wire              ARREADY,
  input  wire [11:0]       ARADDR,
  input  wire [2:0]        ARPROT,
  output reg               RVALID,
  input  wire              RREADY,
  output reg  [31:0]       RDATA,
  output reg  [1:0]        RRESP,
  // clock source ticks and sleep
  input  wire              FAST_TICK,
  input  wire              SEC_TICK,
  input  wire              SLOW_TICK,
  input  wire              SLEEP,
  // panel drive, two-bit level codes
  output reg               DRIVE_EN,
  output reg  [15:0]       COM_LVL,
  output reg  [2*NSEG-1:0] SEG_LVL,
  // bias and contrast controls
  output reg               LADDER_EN,
  output reg               CONTRAST_SUPPLY,
  output reg  [2:0]        BIAS_INT,
  output reg  [2:0]        CONTRAST_LVL,
  output reg  [1:0]        LADDER_PWR,
  output reg               PUMP_EN,
  output reg               PUMP_THIRD,
  output reg  [1:0]        PUMP_CLK_SEL
);

  reg [7:0]  ctrl_r;
  reg [7:0]  phase_r;
  reg [7:0]  bref_r;
  reg [2:0]  cst_r;
  reg [7:0]  lpwr_r;
  reg [7:0]  pump_r;
  reg [7:0]  pix [0:63];
  reg        awr_r;
  reg        arr_r;
  reg [15:0] fdiv_r;
  reg        ht_r;
  reg [3:0]  pre_r;
  reg [2:0]  mul_r;
  reg [3:0]  slice_r;
  reg        par_r;
  reg [3:0]  lad_r;
  integer    i;

  // level code of a segment pin for one slice
  function [1:0] seg_code;
    input dark;
    input ph;
    input stat;
    begin
      if (stat)
        seg_code = (dark ^ ph) ? 2'h3 : 2'h0;
      else if (dark)
        seg_code = ph ? 2'h3 : 2'h0;
      else
        seg_code = ph ? 2'h1 : 2'h2;
    end
  endfunction

  // mapped and word-aligned address
  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `A_STAT);
    end
  endfunction

  wire       en   = ctrl_r[`CTRL_EN];
  wire [2:0] mux  = ctrl_r[`CTRL_MUX_HI:`CTRL_MUX_LO];
  wire [1:0] cs   = ctrl_r[`CTRL_CS_HI:`CTRL_CS_LO];
  wire       typb = phase_r[`PH_TYPB];
  wire [3:0] psc  = phase_r[`PH_PSC_HI:`PH_PSC_LO];
  wire       stat = (mux == 3'h0);

  // ---- bus slave ----
  wire wr_go = AWVALID & WVALID & ~awr_r & ~BVALID;
  wire rd_go = ARVALID & ~arr_r & ~RVALID;
  assign AWREADY = awr_r;
  assign WREADY  = awr_r;
  assign ARREADY = arr_r;

  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    if (ARADDR <= `A_PIX_LAST)
      rd_val = pix[ARADDR[7:2]];
    else begin
      case (ARADDR)
        `A_CTRL:  rd_val = ctrl_r;
        `A_PHASE: rd_val = phase_r;
        `A_BREF:  rd_val = bref_r;
        `A_CST:   rd_val = {5'h00, cst_r};
        `A_LPWR:  rd_val = lpwr_r;
        `A_PUMP:  rd_val = pump_r;
        `A_STAT:  rd_val = {2'h0, DRIVE_EN, par_r, slice_r};
        default:  rd_val = 8'h00;
      endcase
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      awr_r   <= 1'b0;
      arr_r   <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= `RESP_OKAY;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `RESP_OKAY;
      ctrl_r  <= `RST_REG8;
      phase_r <= `RST_REG8;
      bref_r  <= `RST_REG8;
      cst_r   <= `RST_CST;
      lpwr_r  <= `RST_REG8;
      pump_r  <= `RST_REG8;
      for (i = 0; i < 64; i = i + 1)
        pix[i] <= `RST_REG8;
    end else begin
      awr_r <= wr_go;
      arr_r <= rd_go;
      if (BVALID && BREADY)
        BVALID <= 1'b0;
      if (RVALID && RREADY)
        RVALID <= 1'b0;
      if (awr_r) begin
        BVALID <= 1'b1;
        BRESP  <= mapped(AWADDR) ? `RESP_OKAY : `RESP_SLVERR;
        // registers are one byte wide, lane 0 only
        if (mapped(AWADDR) && WSTRB[0]) begin
          if (AWADDR <= `A_PIX_LAST)
            pix[AWADDR[7:2]] <= WDATA[7:0];
          else begin
            case (AWADDR)
              `A_CTRL:  ctrl_r  <= WDATA[7:0];
              `A_PHASE: phase_r <= WDATA[7:0];
              `A_BREF:  bref_r  <= WDATA[7:0];
              `A_CST:   cst_r   <= WDATA[2:0];
              `A_LPWR:  lpwr_r  <= WDATA[7:0];
              `A_PUMP:  pump_r  <= WDATA[7:0];
              default:  ctrl_r  <= ctrl_r;
            endcase
          end
        end
      end
      if (arr_r) begin
        RVALID <= 1'b1;
        RDATA  <= {24'h000000, rd_val};
        RRESP  <= mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ---- clock source and fixed divider ----
  reg        src_tick;
  reg [15:0] div_top;
  always @* begin
    case (cs)
      2'h0: begin
        src_tick = FAST_TICK & ~SLEEP;
        div_top  = HALF_DIV_FAST;
      end
      2'h1: begin
        src_tick = SEC_TICK;
        div_top  = HALF_DIV_SEC;
      end
      2'h2: begin
        src_tick = SLOW_TICK;
        div_top  = HALF_DIV_SLOW;
      end
      default: begin
        src_tick = 1'b0;
        div_top  = HALF_DIV_SLOW;
      end
    endcase
  end

  // fixed divide, half ticks at ~2 kHz
  always @(posedge CLK) begin
    if (RST || !en) begin
      fdiv_r <= 16'h0000;
      ht_r   <= 1'b0;
    end else begin
      ht_r <= 1'b0;
      if (src_tick) begin
        // >= guards a source switch mid-count
        if (fdiv_r >= div_top - 16'h0001) begin
          fdiv_r <= 16'h0000;
          ht_r   <= 1'b1;
        end else
          fdiv_r <= fdiv_r + 16'h0001;
      end
    end
  end

  // ---- slice timing ----
  reg [2:0] mult;
  reg [3:0] nsl;
  always @* begin
    // static and 1/2 mux use 4*(psc+1) per frame
    // static has two slices either type
    if (stat) begin
      mult = 3'h4;
      nsl  = 4'h2;
    end else if (mux == 3'h1) begin
      mult = typb ? 3'h4 : 3'h2;
      nsl  = typb ? 4'h2 : 4'h4;
    end else begin
      mult = typb ? 3'h2 : 3'h1;
      nsl  = typb ? {1'b0, mux} + 4'h1 : {mux, 1'b0} + 4'h2;
    end
  end

  always @(posedge CLK) begin
    if (RST || !en) begin
      pre_r   <= 4'h0;
      mul_r   <= 3'h0;
      slice_r <= 4'h0;
      par_r   <= 1'b0;
      lad_r   <= 4'h0;
    end else if (ht_r) begin
      if (lad_r != 4'hF)
        lad_r <= lad_r + 4'h1;
      if (pre_r >= psc) begin
        pre_r <= 4'h0;
        if (mul_r >= mult - 3'h1) begin
          mul_r <= 3'h0;
          lad_r <= 4'h0;
          if (slice_r >= nsl - 4'h1) begin
            slice_r <= 4'h0;
            par_r   <= ~par_r;
          end else
            slice_r <= slice_r + 4'h1;
        end else
          mul_r <= mul_r + 3'h1;
      end else
        pre_r <= pre_r + 4'h1;
    end
  end

  // ---- waveform levels ----
  reg [2:0]          com;
  reg                ph;
  reg [15:0]         com_nxt;
  reg [2*NSEG-1:0]   seg_nxt;
  integer            s;
  always @* begin
    // type bit selects A or B
    // A flips inside slot, B per frame
    if (stat || !typb) begin
      com = stat ? 3'h0 : slice_r[3:1];
      ph  = slice_r[0];
    end else begin
      com = slice_r[2:0];
      ph  = par_r;
    end
    com_nxt = 16'h0000;
    seg_nxt = {2*NSEG{1'b0}};
    if (en) begin
      for (s = 0; s < 8; s = s + 1) begin
        // levels mirror each phase for zero DC
        if (stat)
          com_nxt[2*s +: 2] = ph ? 2'h3 : 2'h0;
        else if (s == com)
          com_nxt[2*s +: 2] = ph ? 2'h0 : 2'h3;
        else
          com_nxt[2*s +: 2] = ph ? 2'h2 : 2'h1;
      end
      for (s = 0; s < NSEG; s = s + 1)
        // dark gets 3 steps, clear at most 1
        seg_nxt[2*s +: 2] = seg_code(pix[com*8 + s/8][s%8], ph, stat);
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      DRIVE_EN        <= 1'b0;
      COM_LVL         <= 16'h0000;
      SEG_LVL         <= {2*NSEG{1'b0}};
      LADDER_EN       <= 1'b0;
      CONTRAST_SUPPLY <= 1'b0;
      BIAS_INT        <= 3'h0;
      CONTRAST_LVL    <= 3'h0;
      LADDER_PWR      <= 2'h0;
      PUMP_EN         <= 1'b0;
      PUMP_THIRD      <= 1'b0;
      PUMP_CLK_SEL    <= 2'h0;
    end else begin
      DRIVE_EN        <= en;
      COM_LVL         <= com_nxt;
      SEG_LVL         <= seg_nxt;
      LADDER_EN       <= bref_r[`BREF_IRE];
      CONTRAST_SUPPLY <= bref_r[`BREF_IRS];
      BIAS_INT        <= bref_r[`BREF_PIN_HI:`BREF_PIN_LO];
      if (bref_r[`BREF_IRE])
        CONTRAST_LVL <= cst_r;
      else if (pump_r[`PUMP_EN])
        CONTRAST_LVL <= pump_r[`PUMP_CST_HI:`PUMP_CST_LO];
      else
        CONTRAST_LVL <= 3'h0;
      // mode A for interval, then mode B
      if (!en)
        LADDER_PWR <= 2'h0;
      else if (lad_r < lpwr_r[`LPWR_T_HI:`LPWR_T_LO])
        LADDER_PWR <= lpwr_r[`LPWR_A_HI:`LPWR_A_LO];
      else
        LADDER_PWR <= lpwr_r[`LPWR_B_HI:`LPWR_B_LO];
      PUMP_EN      <= pump_r[`PUMP_EN];
      PUMP_THIRD   <= pump_r[`PUMP_M13];
      // pump clock select apart from frame clock
      PUMP_CLK_SEL <= pump_r[`PUMP_CLK_HI:`PUMP_CLK_LO];
    end
  end

endmodule

// File: common/lcd_drv_regs.vh
`ifndef LCD_DRV_REGS_VH
`define LCD_DRV_REGS_VH
// register byte addresses
`define A_PIX_LAST 12'h0FC
`define A_CTRL     12'h100
`define A_PHASE    12'h104
`define A_BREF     12'h108
`define A_CST      12'h10C
`define A_LPWR     12'h110
`define A_PUMP     12'h114
`define A_STAT     12'h118
// control_reg fields
`define CTRL_EN     7
`define CTRL_MUX_HI 4
`define CTRL_MUX_LO 2
`define CTRL_CS_HI  1
`define CTRL_CS_LO  0
// phase_reg fields
`define PH_TYPB     7
`define PH_PSC_HI   3
`define PH_PSC_LO   0
// bias_reference_reg fields
`define BREF_IRE    7
`define BREF_IRS    6
`define BREF_PIN_HI 2
`define BREF_PIN_LO 0
// ladder_power_reg fields
`define LPWR_A_HI   1
`define LPWR_A_LO   0
`define LPWR_B_HI   3
`define LPWR_B_LO   2
`define LPWR_T_HI   7
`define LPWR_T_LO   4
// charge_pump_reg fields
`define PUMP_EN     7
`define PUMP_M13    6
`define PUMP_CST_HI 5
`define PUMP_CST_LO 3
`define PUMP_CLK_HI 1
`define PUMP_CLK_LO 0
// reset values
`define RST_REG8    8'h00
`define RST_CST     3'h0
// fixed divider, half of the ~1 kHz period in source ticks
`define DIV_FAST_HALF 16'h1000
`define DIV_SEC_HALF  16'h0010
`define DIV_SLOW_HALF 16'h0010
// bus answers
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// File: sim/lcd_glass_model.sv
`timescale 1ns/1ns
module lcd_glass_model (
  // control
  input  wire               clk,
  input  wire               clr,
  input  wire               win,
  // com0 against dark seg0 and clear seg1
  input  wire [15:0]        com_lvl,
  input  wire [127:0]       seg_lvl,
  // window sums
  output reg  signed [31:0] dc_on,
  output reg  signed [31:0] e_on,
  output reg  signed [31:0] e_off
);
  wire signed [31:0] v_on  = {30'h0, com_lvl[1:0]} - {30'h0, seg_lvl[1:0]};
  wire signed [31:0] v_off = {30'h0, com_lvl[1:0]} - {30'h0, seg_lvl[3:2]};
  always @(posedge clk) begin
    if (clr) begin
      dc_on <= 32'h0;
      e_on  <= 32'h0;
      e_off <= 32'h0;
    end else if (win) begin
      dc_on <= dc_on + v_on;
      e_on  <= e_on + v_on * v_on;
      e_off <= e_off + v_off * v_off;
    end
  end
endmodule

// File: sim/lcd_drv_properties.sv
`timescale 1ns/1ns
module lcd_drv_props #(
  parameter NSEG = 64
) (
  input wire              CLK,
  input wire              RST,
  input wire              AWVALID,
  input wire              WVALID,
  input wire              AWREADY,
  input wire              WREADY,
  input wire              BVALID,
  input wire              BREADY,
  input wire [1:0]        BRESP,
  input wire              ARREADY,
  input wire              RVALID,
  input wire              RREADY,
  input wire [31:0]       RDATA,
  input wire              DRIVE_EN,
  input wire [15:0]       COM_LVL,
  input wire [2*NSEG-1:0] SEG_LVL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wr_taken_a: assert property ($rose(AWREADY) |-> $past(AWVALID && WVALID))
    else $error("write taken without both valids");
  wr_answer_a: assert property (AWREADY |-> WREADY ##1 (BVALID && !AWREADY))
    else $error("write answer late or ready not paired");
  wr_block_a: assert property (BVALID |-> !AWREADY)
    else $error("write taken while response pending");
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  rd_answer_a: assert property (ARREADY |=> RVALID && !ARREADY)
    else $error("read answer late");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  rd_upper_a: assert property (RVALID |-> RDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  panel_quiet_a: assert property (!DRIVE_EN [*2] |-> COM_LVL == 16'h0000 && SEG_LVL == '0)
    else $error("levels driven while disabled");
  cover property (BVALID && !BREADY);
  cover property (RVALID && !RREADY);
  cover property ($rose(DRIVE_EN));
  cover property ($fell(DRIVE_EN));
endmodule

bind lcd_segment_common_driver lcd_drv_props #(.NSEG(NSEG)) u_props (
  .CLK(CLK), .RST(RST), .AWVALID(AWVALID), .WVALID(WVALID), .AWREADY(AWREADY),
  .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
  .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
  .DRIVE_EN(DRIVE_EN), .COM_LVL(COM_LVL), .SEG_LVL(SEG_LVL));

// File: sim/lcd_segment_common_driver_test.sv
`timescale 1ns/1ns
`include "lcd_drv_regs.vh"
module lcd_segment_common_driver_test;
  reg                CLK = 1'b0;
  reg                RST = 1'b1;
  reg                AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  reg                ARVALID = 1'b0, RREADY = 1'b0, SLEEP = 1'b0;
  reg                tk = 1'b0, clr = 1'b0, win = 1'b0;
  reg  [11:0]        AWADDR = 12'h000, ARADDR = 12'h000;
  reg  [31:0]        WDATA = 32'h0;
  reg  [3:0]         WSTRB = 4'h0;
  wire               AWREADY, WREADY, BVALID, ARREADY, RVALID, DRIVE_EN;
  wire               LADDER_EN, CONTRAST_SUPPLY, PUMP_EN, PUMP_THIRD;
  wire [1:0]         BRESP, RRESP, PUMP_CLK_SEL, LADDER_PWR;
  wire [2:0]         BIAS_INT, CONTRAST_LVL;
  wire [31:0]        RDATA;
  wire [15:0]        COM_LVL;
  wire [127:0]       SEG_LVL;
  wire signed [31:0] dc_on, e_on, e_off;
  integer            mismatches = 0, compares = 0, cyc = 0;
  integer            k, n, mx, psc, cs, p, sl;
  integer            lpa = 0;
  reg  [1:0]         rsp;
  reg  [31:0]        rdat;

  always #5 CLK = ~CLK;
  // one source tick every other cycle
  always @(posedge CLK) tk <= ~tk;
  // cycles of the window spent in ladder power mode A
  always @(posedge CLK) begin
    if (clr)
      lpa <= 0;
    else if (win && LADDER_PWR == 2'h1)
      lpa <= lpa + 1;
  end

  lcd_segment_common_driver #(.HALF_DIV_FAST(16'h0002), .HALF_DIV_SEC(16'h0002),
    .HALF_DIV_SLOW(16'h0002)) u_dut (
    .CLK(CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .FAST_TICK(tk), .SEC_TICK(tk),
    .SLOW_TICK(tk), .SLEEP(SLEEP), .DRIVE_EN(DRIVE_EN), .COM_LVL(COM_LVL),
    .SEG_LVL(SEG_LVL), .LADDER_EN(LADDER_EN), .CONTRAST_SUPPLY(CONTRAST_SUPPLY),
    .BIAS_INT(BIAS_INT), .CONTRAST_LVL(CONTRAST_LVL), .LADDER_PWR(LADDER_PWR),
    .PUMP_EN(PUMP_EN), .PUMP_THIRD(PUMP_THIRD), .PUMP_CLK_SEL(PUMP_CLK_SEL));

  lcd_glass_model u_glass (.clk(CLK), .clr(clr), .win(win), .com_lvl(COM_LVL),
    .seg_lvl(SEG_LVL), .dc_on(dc_on), .e_on(e_on), .e_off(e_off));

  task end_sim;
    begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task settle;
    begin
      @(posedge CLK);
      #1;
    end
  endtask

  // ready raised a cycle late so the answer has to wait
  task wr(input [11:0] a, input [7:0] d, input [3:0] s);
    begin
      @(posedge CLK);
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      AWADDR <= a;
      WDATA <= {24'h000000, d};
      WSTRB <= s;
      do @(posedge CLK); while (!AWREADY);
      AWVALID <= 1'b0;
      WVALID <= 1'b0;
      @(posedge CLK);
      BREADY <= 1'b1;
      do @(posedge CLK); while (!BVALID);
      rsp = BRESP;
      BREADY <= 1'b0;
    end
  endtask

  task rd(input [11:0] a);
    begin
      @(posedge CLK);
      ARVALID <= 1'b1;
      ARADDR <= a;
      do @(posedge CLK); while (!ARREADY);
      ARVALID <= 1'b0;
      @(posedge CLK);
      RREADY <= 1'b1;
      do @(posedge CLK); while (!RVALID);
      rdat = RDATA;
      rsp = RRESP;
      RREADY <= 1'b0;
    end
  endtask

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end

  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rd(`A_CTRL);
    chk(rdat, 32'h0);
    rd(12'h11C);
    chk(rsp, `RESP_SLVERR);
    // com 2 seg 13 sits in row 17, bit 5
    wr(12'h044, 8'h20, 4'h1);
    wr(12'h044, 8'hFF, 4'h0);
    chk(rsp, `RESP_OKAY);
    wr(12'h046, 8'h01, 4'h1);
    chk(rsp, `RESP_SLVERR);
    rd(12'h044);
    chk(rdat, 32'h20);
    wr(`A_BREF, 8'hC5, 4'h1);
    wr(`A_CST, 8'h06, 4'h1);
    wr(`A_PUMP, 8'hDA, 4'h1);
    settle;
    chk({LADDER_EN, CONTRAST_SUPPLY, BIAS_INT}, 32'h1D);
    chk(CONTRAST_LVL, 32'h6);
    chk({PUMP_EN, PUMP_THIRD, PUMP_CLK_SEL}, 32'hE);
    wr(`A_BREF, 8'h00, 4'h1);
    wr(`A_PUMP, 8'h98, 4'h1);
    settle;
    chk({LADDER_EN, CONTRAST_LVL, PUMP_THIRD}, 32'h6);
    wr(`A_LPWR, 8'h31, 4'h1);
    rd(`A_LPWR);
    chk(rdat, 32'h31);
    wr(12'h000, 8'h01, 4'h1);
    for (k = 0; k < 9; k = k + 1) begin
      mx = k % 8;
      n = (mx == 0) ? 1 : mx + 1;
      psc = k % 4;
      cs = k % 3;
      // window of two frames, 4 cycles per half tick
      p = 16 * ((mx < 2) ? 4 : n) * (psc + 1);
      // slices per frame for this mode
      sl = (mx == 0) ? 2 : (k[0] ^ k[3]) ? ((mx == 1) ? 2 : n) : 2 * n;
      SLEEP <= (cs != 0);
      wr(`A_PHASE, {k[0] ^ k[3], 3'b000, psc[3:0]}, 4'h1);
      wr(`A_CTRL, {3'b100, mx[2:0], cs[1:0]}, 4'h1);
      repeat (20) @(posedge CLK);
      clr <= 1'b1;
      @(posedge CLK);
      clr <= 1'b0;
      win <= 1'b1;
      repeat (p) @(posedge CLK);
      win <= 1'b0;
      settle;
      chk(dc_on, 32'h0);
      chk(e_on, (mx == 0) ? 9 * p : p * (n + 8) / n);
      chk(e_off, (mx == 0) ? 0 : p);
      chk(lpa, 8 * sl * ((p / (8 * sl) < 3) ? p / (8 * sl) : 3));
      rd(`A_STAT);
      chk({DRIVE_EN, rdat[5]}, 32'h3);
      wr(`A_CTRL, 8'h00, 4'h1);
      settle;
      rd(`A_STAT);
      chk({DRIVE_EN, LADDER_PWR, rdat[7:0]}, 32'h0);
    end
    // fast source must stand still in sleep
    SLEEP <= 1'b1;
    wr(`A_CTRL, 8'h80, 4'h1);
    repeat (40) @(posedge CLK);
    rd(`A_STAT);
    chk(rdat, 32'h20);
    end_sim;
  end
endmodule
